//--- hdl/gprr_consts.vh
// constants for the gps report packet responder
`ifndef GPRR_CONSTS_VH
`define GPRR_CONSTS_VH
// axi4-lite register byte offsets
`define GPRR_REG_CMD 8'h00
`define GPRR_REG_STATUS 8'h04
`define GPRR_REG_DYN 8'h08
`define GPRR_REG_ELEV 8'h0c
`define GPRR_REG_SIGL 8'h10
`define GPRR_REG_PDOP 8'h14
`define GPRR_REG_SWITCH 8'h18
`define GPRR_REG_OPTIONS 8'h1c
`define GPRR_REG_TIME 8'h20
`define GPRR_REG_OSC 8'h24
`define GPRR_REG_BIAS 8'h28
`define GPRR_REG_RATE 8'h2c
`define GPRR_REG_TFIX 8'h30
`define GPRR_REG_FIX 8'h34
// packet identifiers
`define GPRR_Q_PARAMS 8'h2c
`define GPRR_Q_OSC 8'h2d
`define GPRR_Q_SETTIME 8'h2e
`define GPRR_Q_OPTIONS 8'h35
`define GPRR_R_PARAMS 8'h4c
`define GPRR_R_OSC 8'h4d
`define GPRR_R_SETTIME 8'h4e
`define GPRR_R_ONESAT 8'h54
`define GPRR_R_OPTIONS 8'h55
`define GPRR_R_LLA_S 8'h4a
`define GPRR_R_LLA_D 8'h84
`define GPRR_R_SUPER 8'h8f
`define GPRR_R_SUPER_ASC 8'h8e
`define GPRR_SUB_BIN 8'h02
`define GPRR_SUB_ASCII 8'h01
// dynamics codes
`define GPRR_DYN_KEEP 8'h00
`define GPRR_DYN_LAND 8'h01
`define GPRR_DYN_SEA 8'h02
`define GPRR_DYN_AIR 8'h03
`define GPRR_DYN_STATIC 8'h04
// reset values (ieee single), options reset byte and used-bit mask
`define GPRR_ELEV_RST 32'h3e32ca58
`define GPRR_SIGL_RST 32'h40c00000
`define GPRR_PDOP_RST 32'h41400000
`define GPRR_SWITCH_RST 32'h41000000
`define GPRR_OPT_RST 8'h01
`define GPRR_OPT_USED 8'h7f
// option bit positions
`define GPRR_OPT_ECEF 0
`define GPRR_OPT_LLA 1
`define GPRR_OPT_PREC 4
`define GPRR_OPT_SUPER 5
`define GPRR_OPT_ASCII 6
// answer bytes and minimum satellite count
`define GPRR_ASCII_Y 8'h59
`define GPRR_ASCII_N 8'h4e
`define GPRR_MIN_SATS 4'h4
`endif

//--- hdl/gprr_float_cmp.v
// ieee single comparison: sign test and a <= b for positive values
`timescale 1ns/1ns
module gprr_float_cmp
(
   input wire [31:0] i_a,   // first operand
   input wire [31:0] i_b,   // second operand
   output wire o_a_neg,     // a has its sign bit set
   output wire o_a_le_b     // a not greater than b, both positive
);
   // positive floats order as unsigned integers
   assign o_a_neg = i_a[31];
   assign o_a_le_b = (!i_a[31]) && (!i_b[31]) && (i_a[30:0] <= i_b[30:0]);
endmodule

//--- hdl/gprr_tx_ser.v
// byte serialiser for one outgoing report packet
`timescale 1ns/1ns
module gprr_tx_ser
#(
   parameter MAXB = 18
)
(
   input wire i_clk,               // system clock
   input wire i_rst,               // synchronous reset, high
   input wire i_load,              // start a packet
   input wire [8*MAXB-1:0] i_data, // bytes, byte 0 in low bits
   input wire [4:0] i_len,         // byte count
   output wire o_busy,             // packet in progress
   output reg o_valid,             // byte valid
   output reg [7:0] o_byte,        // byte out
   output reg o_last,              // last byte of packet
   input wire i_ready              // sink takes byte
);
   reg [8*MAXB-1:0] buf_q;
   reg [4:0] left;
   assign o_busy = o_valid;
   // shift out one byte per accepted handshake
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         buf_q <= {8*MAXB{1'b0}};
         left <= 5'h00;
         o_valid <= 1'b0;
         o_byte <= 8'h00;
         o_last <= 1'b0;
      end
      else if (i_load && !o_valid)
      begin
         buf_q <= i_data >> 8;
         o_byte <= i_data[7:0];
         left <= i_len - 5'h01;
         o_valid <= 1'b1;
         o_last <= (i_len == 5'h01);
      end
      else if (o_valid && i_ready)
      begin
         if (left == 5'h00)
         begin
            o_valid <= 1'b0;
            o_last <= 1'b0;
         end
         else
         begin
            o_byte <= buf_q[7:0];
            buf_q <= buf_q >> 8;
            left <= left - 5'h01;
            o_last <= (left == 5'h01);
         end
      end
   end
endmodule

//--- hdl/gprr_responder.v
// report packet responder with axi4-lite registers and byte stream out
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "gprr_consts.vh"
module gprr_responder
(
   input wire i_clk,            // 50 mhz clock
   input wire i_rst,            // synchronous reset, high
   input wire [7:0] s_axi_awaddr,  // write address
   input wire s_axi_awvalid,    // write address valid
   output wire s_axi_awready,   // write address ready
   input wire [31:0] s_axi_wdata,  // write data
   input wire [3:0] s_axi_wstrb,   // write strobes
   input wire s_axi_wvalid,     // write data valid
   output wire s_axi_wready,    // write data ready
   output reg [1:0] s_axi_bresp,   // write response
   output reg s_axi_bvalid,     // write response valid
   input wire s_axi_bready,     // write response ready
   input wire [7:0] s_axi_araddr,  // read address
   input wire s_axi_arvalid,    // read address valid
   output wire s_axi_arready,   // read address ready
   output reg [31:0] s_axi_rdata,  // read data
   output reg [1:0] s_axi_rresp,   // read response
   output reg s_axi_rvalid,     // read data valid
   input wire s_axi_rready,     // read data ready
   input wire i_bbram_valid,    // battery-backed copy present
   input wire [31:0] i_bb_elev, // stored elevation mask
   input wire [31:0] i_bb_sigl, // stored signal mask
   input wire [31:0] i_bb_pdop, // stored pdop mask
   input wire [31:0] i_bb_sw,   // stored pdop switch
   input wire [7:0] i_bb_dyn,   // stored dynamics code
   output reg o_bb_we,          // write parameters to backup
   output wire [135:0] o_bb_data, // parameter image for backup
   output wire o_tx_valid,      // report byte valid
   output wire [7:0] o_tx_byte, // report byte
   output wire o_tx_last,       // last byte of report
   input wire i_tx_ready,       // host handler takes byte
   output reg o_fix_3d,         // 3-d fix allowed
   output reg [31:0] o_pps_corr, // bias applied to one pps
   output reg o_time_adopted    // host time adopted
);
   // parameter state
   reg [7:0] dyn;
   reg [31:0] elev;
   reg [31:0] sigl;
   reg [31:0] pdop;
   reg [31:0] pswitch;
   reg [7:0] options;
   reg [31:0] host_time;
   reg [31:0] osc;
   reg [31:0] bias;
   reg [31:0] rate;
   reg [31:0] tfix;
   reg [31:0] fix_pdop;
   reg [3:0] n_sats;
   reg sat_time_seen;
   reg one_sat;
   reg fix_event;
   reg [7:0] cmd_id;
   reg cmd_pend;
   reg restored;
   // axi write path
   reg aw_got;
   reg w_got;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire wr_go;
   wire [31:0] wr_word;
   // serialiser
   reg ld;
   reg [143:0] ld_data;
   reg [4:0] ld_len;
   wire ser_busy;
   wire elev_neg;
   wire sigl_neg;
   wire pdop_neg;
   wire sw_neg;
   wire pdop_ok;
   wire unused_le;
   wire unused_n;

   // merge byte strobes into the old value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      begin
         merge = {st[3] ? nw[31:24] : old[31:24],
                  st[2] ? nw[23:16] : old[23:16],
                  st[1] ? nw[15:8] : old[15:8],
                  st[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   gprr_float_cmp u_c_elev (.i_a(wr_word), .i_b(32'h00000000),
      .o_a_neg(elev_neg), .o_a_le_b());
   assign sigl_neg = elev_neg;
   assign pdop_neg = elev_neg;
   assign sw_neg = elev_neg;
   gprr_float_cmp u_c_pdop (.i_a(fix_pdop), .i_b(pdop),
      .o_a_neg(unused_n), .o_a_le_b(pdop_ok));
   assign unused_le = unused_n;

   // axi handshake: accept address and data in either order
   assign s_axi_awready = !aw_got && !s_axi_bvalid;
   assign s_axi_wready = !w_got && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = aw_got && w_got && !s_axi_bvalid;
   assign wr_word = w_data;
   assign o_bb_data = {dyn, elev, sigl, pdop, pswitch};

   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[7:2] > `GPRR_REG_FIX >> 2) ?
               2'b10 : 2'b00;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // register writes and parameter updates
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         dyn <= `GPRR_DYN_AIR;
         elev <= `GPRR_ELEV_RST;
         sigl <= `GPRR_SIGL_RST;
         pdop <= `GPRR_PDOP_RST;
         pswitch <= `GPRR_SWITCH_RST;
         options <= `GPRR_OPT_RST;
         host_time <= 32'h00000000;
         osc <= 32'h00000000;
         bias <= 32'h00000000;
         rate <= 32'h00000000;
         tfix <= 32'h00000000;
         fix_pdop <= 32'h00000000;
         n_sats <= 4'h0;
         sat_time_seen <= 1'b0;
         one_sat <= 1'b0;
         fix_event <= 1'b0;
         cmd_id <= 8'h00;
         cmd_pend <= 1'b0;
         o_bb_we <= 1'b0;
         restored <= 1'b0;
         o_time_adopted <= 1'b0;
      end
      else
      begin
         o_bb_we <= 1'b0;
         fix_event <= 1'b0;
         if (!restored)
         begin
            restored <= 1'b1;
            if (i_bbram_valid)
            begin
               dyn <= i_bb_dyn;
               elev <= i_bb_elev;
               sigl <= i_bb_sigl;
               pdop <= i_bb_pdop;
               pswitch <= i_bb_sw;
            end
         end
         if (cmd_pend && !ser_busy && !ld)
            cmd_pend <= 1'b0;
         if (wr_go)
         begin
            case (aw_addr)
               `GPRR_REG_CMD:
               begin
                  cmd_id <= wr_word[7:0];
                  cmd_pend <= 1'b1;
                  if (wr_word[7:0] == `GPRR_Q_SETTIME && !sat_time_seen)
                     o_time_adopted <= 1'b1;
               end
               `GPRR_REG_STATUS:
               begin
                  sat_time_seen <= wr_word[0];
                  one_sat <= wr_word[1];
                  n_sats <= wr_word[7:4];
                  fix_event <= wr_word[8];
               end
               `GPRR_REG_DYN:
                  if (wr_word[7:0] != `GPRR_DYN_KEEP &&
                      wr_word[7:0] <= `GPRR_DYN_STATIC)
                  begin
                     dyn <= wr_word[7:0];
                     o_bb_we <= 1'b1;
                  end
               `GPRR_REG_ELEV:
                  if (!elev_neg)
                  begin
                     elev <= merge(elev, wr_word, w_strb);
                     o_bb_we <= 1'b1;
                  end
               `GPRR_REG_SIGL:
                  if (!sigl_neg)
                  begin
                     sigl <= merge(sigl, wr_word, w_strb);
                     o_bb_we <= 1'b1;
                  end
               `GPRR_REG_PDOP:
                  if (!pdop_neg)
                  begin
                     pdop <= merge(pdop, wr_word, w_strb);
                     o_bb_we <= 1'b1;
                  end
               `GPRR_REG_SWITCH:
                  if (!sw_neg)
                  begin
                     pswitch <= merge(pswitch, wr_word, w_strb);
                     o_bb_we <= 1'b1;
                  end
               `GPRR_REG_OPTIONS:
                  if (w_strb[0])
                     options <= wr_word[7:0] & `GPRR_OPT_USED;
               `GPRR_REG_TIME:
                  host_time <= merge(host_time, wr_word, w_strb);
               `GPRR_REG_OSC:
                  osc <= merge(osc, wr_word, w_strb);
               `GPRR_REG_BIAS:
                  bias <= merge(bias, wr_word, w_strb);
               `GPRR_REG_RATE:
                  rate <= merge(rate, wr_word, w_strb);
               `GPRR_REG_TFIX:
                  tfix <= merge(tfix, wr_word, w_strb);
               `GPRR_REG_FIX:
                  fix_pdop <= merge(fix_pdop, wr_word, w_strb);
               default:
                  cmd_pend <= cmd_pend;
            endcase
         end
      end
   end

   // fix mode and one-pps correction
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_fix_3d <= 1'b0;
         o_pps_corr <= 32'h00000000;
      end
      else
      begin
         o_fix_3d <= (n_sats >= `GPRR_MIN_SATS) && pdop_ok;
         if (fix_event && one_sat)
            o_pps_corr <= bias;
      end
   end

   // build the report for a query or a fix event
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ld <= 1'b0;
         ld_data <= 144'h0;
         ld_len <= 5'h00;
      end
      else if (ld)
         ld <= 1'b0;
      else if (!ser_busy && cmd_pend)
      begin
         ld <= 1'b1;
         case (cmd_id)
            `GPRR_Q_PARAMS:
            begin
               ld_data <= {pswitch, pdop, sigl, elev, dyn,
                           `GPRR_R_PARAMS};
               ld_len <= 5'h12;
            end
            `GPRR_Q_OSC:
            begin
               ld_data <= {104'h0, osc, `GPRR_R_OSC};
               ld_len <= 5'h05;
            end
            `GPRR_Q_SETTIME:
            begin
               ld_data <= {128'h0, (sat_time_seen ? `GPRR_ASCII_N :
                           `GPRR_ASCII_Y), `GPRR_R_SETTIME};
               ld_len <= 5'h02;
            end
            `GPRR_Q_OPTIONS:
            begin
               ld_data <= {128'h0, options, `GPRR_R_OPTIONS};
               ld_len <= 5'h02;
            end
            default:
               ld <= 1'b0;
         endcase
      end
      else if (!ser_busy && fix_event)
      begin
         ld <= 1'b1;
         if (one_sat)
         begin
            ld_data <= {40'h0, tfix, rate, bias, `GPRR_R_ONESAT};
            ld_len <= 5'h0d;
         end
         else if (options[`GPRR_OPT_SUPER])
         begin
            ld_data <= {128'h0, options[`GPRR_OPT_ASCII] ? {`GPRR_SUB_ASCII,
               `GPRR_R_SUPER_ASC} : {`GPRR_SUB_BIN, `GPRR_R_SUPER}};
            ld_len <= 5'h02;
         end
         else if (options[`GPRR_OPT_LLA])
         begin
            ld_data <= {136'h0, options[`GPRR_OPT_PREC] ?
               `GPRR_R_LLA_D : `GPRR_R_LLA_S};
            ld_len <= 5'h01;
         end
         else
            ld <= 1'b0;
      end
   end

   gprr_tx_ser #(.MAXB(18)) u_ser (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_load(ld),
      .i_data(ld_data),
      .i_len(ld_len),
      .o_busy(ser_busy),
      .o_valid(o_tx_valid),
      .o_byte(o_tx_byte),
      .o_last(o_tx_last),
      .i_ready(i_tx_ready)
   );

   // axi read path, one cycle latency
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr)
            `GPRR_REG_CMD: s_axi_rdata <= {23'h0, cmd_pend, cmd_id};
            `GPRR_REG_STATUS: s_axi_rdata <= {21'h0, o_time_adopted,
               o_fix_3d, ser_busy, n_sats, 2'b00, one_sat, sat_time_seen};
            `GPRR_REG_DYN: s_axi_rdata <= {24'h0, dyn};
            `GPRR_REG_ELEV: s_axi_rdata <= elev;
            `GPRR_REG_SIGL: s_axi_rdata <= sigl;
            `GPRR_REG_PDOP: s_axi_rdata <= pdop;
            `GPRR_REG_SWITCH: s_axi_rdata <= pswitch;
            `GPRR_REG_OPTIONS: s_axi_rdata <= {24'h0, options};
            `GPRR_REG_TIME: s_axi_rdata <= host_time;
            `GPRR_REG_OSC: s_axi_rdata <= osc;
            `GPRR_REG_BIAS: s_axi_rdata <= bias;
            `GPRR_REG_RATE: s_axi_rdata <= rate;
            `GPRR_REG_TFIX: s_axi_rdata <= tfix;
            `GPRR_REG_FIX: s_axi_rdata <= fix_pdop;
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

//--- sim/gprr_resp_asserts.sv
// port assertions for the report packet responder
`timescale 1ns/1ns
`include "gprr_consts.vh"
module gprr_resp_asserts
(
   input wire i_clk, // clock
   input wire i_rst, // reset
   input wire [7:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // address valid
   input wire s_axi_arready, // address ready
   input wire [31:0] s_axi_rdata, // read data
   input wire [1:0] s_axi_rresp, // read response
   input wire s_axi_rvalid, // data valid
   input wire s_axi_rready, // data ready
   input wire o_tx_valid, // byte valid
   input wire [7:0] o_tx_byte, // byte
   input wire o_tx_last, // last byte
   input wire i_tx_ready, // byte taken
   input wire [135:0] o_bb_data // backup image
);
   reg in_pkt; // inside a packet, past its id
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence tx_stall;
      o_tx_valid && !i_tx_ready;
   endsequence
   // tell the id byte apart from the body
   always @(posedge i_clk)
   begin
      if (i_rst)
         in_pkt <= 1'h0;
      else if (o_tx_valid && i_tx_ready)
         in_pkt <= !o_tx_last;
   end
   a_reset_image: assert property (disable iff (1'h0)
      i_rst |=> o_bb_data == {`GPRR_DYN_AIR, `GPRR_ELEV_RST,
      `GPRR_SIGL_RST, `GPRR_PDOP_RST, `GPRR_SWITCH_RST})
      else $error("parameters not at defaults after reset");
   a_report_id: assert property (o_tx_valid && !in_pkt |->
      o_tx_byte inside {8'h4c, 8'h4d, 8'h4e, 8'h54, 8'h55, 8'h8f, 8'h4a,
      8'h84, 8'h8e})
      else $error("report opens without a valid id");
   a_tx_stands: assert property (tx_stall |=> o_tx_valid &&
      $stable(o_tx_byte) && $stable(o_tx_last))
      else $error("report byte changed before taken");
   a_read_answer: assert property (rd_take |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_read_unmapped: assert property (rd_take ##0 s_axi_araddr > 8'h34 |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_opt_unused: assert property (rd_take ##0
      s_axi_araddr == 8'h1c |=> s_axi_rdata[31:7] == 25'h0)
      else $error("unused option bits read as one");
   a_dyn_range: assert property (rd_take ##0
      s_axi_araddr == 8'h08 |=> s_axi_rdata inside {[32'h1:32'h4]})
      else $error("stored dynamics code out of range");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
endmodule
bind gprr_responder gprr_resp_asserts chk_u (.i_clk(i_clk), .i_rst(i_rst),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .o_tx_valid(o_tx_valid),
   .o_tx_byte(o_tx_byte), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready),
   .o_bb_data(o_bb_data));

//--- sim/gprr_host_sink.sv
// host packet handler model that collects report bytes
`timescale 1ns/1ns
module gprr_host_sink
(
   input wire i_clk, // clock
   input wire i_rst, // reset
   input wire i_clr, // forget last packet
   input wire i_slow, // take every other cycle
   input wire i_valid, // byte offered
   input wire [7:0] i_byte, // offered byte
   input wire i_last, // last byte
   output wire o_ready, // byte accepted
   output reg [4:0] o_cnt, // bytes collected
   output reg o_done // packet closed
);
   reg [7:0] mem [0:31]; // bytes, id first
   reg phase; // slow pacing
   // a slow handler stalls every other cycle
   assign o_ready = !i_slow || phase;
   // collect whole bytes in arrival order
   always @(posedge i_clk)
   begin
      phase <= i_rst ? 1'h0 : !phase;
      if (i_rst || i_clr)
      begin
         o_cnt <= 5'h0;
         o_done <= 1'h0;
      end
      else if (i_valid && o_ready && !o_done)
      begin
         mem[o_cnt] <= i_byte;
         o_cnt <= o_cnt + 5'h1;
         o_done <= i_last;
      end
   end
endmodule

//--- sim/test_gps_report_packet_responder.sv
// self-checking bench for the report packet responder
`timescale 1ns/1ns
`include "gprr_consts.vh"
module test_gps_report_packet_responder;
   localparam [39:0] FIX_OPT = 40'h00_12_02_22_62;
   localparam [39:0] FIX_ID = 40'h00_84_4a_8f_8e;
   localparam [39:0] FIX_LEN = 40'h00_01_01_02_02;
   reg i_clk = 1'h0;
   reg i_rst = 1'h1;
   reg awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
   reg bbv = 1'h0, slow = 1'h0, clr = 1'h0;
   reg [7:0] awa = 8'h0, ara = 8'h0, bbdyn = 8'h1;
   reg [31:0] wd = 32'h0, bbf = 32'h3f800000, rdv;
   reg [3:0] ws = 4'hf;
   reg [1:0] rsp;
   wire awr, wrd, arr, bv, rv, txv, txl, txr, bbwe, fix3d, adopted, done;
   wire [1:0] br, rr;
   wire [31:0] rdat, corr;
   wire [7:0] txb;
   wire [135:0] bbd;
   wire [4:0] cnt;
   integer error_cnt = 0;
   integer tests_run = 0;
   integer we_cnt = 0;
   // 50 mhz clock
   always #10 i_clk = ~i_clk;
   gprr_responder dut_u (.i_clk(i_clk), .i_rst(i_rst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .i_bbram_valid(bbv), .i_bb_elev(bbf),
      .i_bb_sigl(bbf), .i_bb_pdop(bbf), .i_bb_sw(bbf), .i_bb_dyn(bbdyn),
      .o_bb_we(bbwe), .o_bb_data(bbd), .o_tx_valid(txv), .o_tx_byte(txb),
      .o_tx_last(txl), .i_tx_ready(txr), .o_fix_3d(fix3d),
      .o_pps_corr(corr), .o_time_adopted(adopted));
   gprr_host_sink host_u (.i_clk(i_clk), .i_rst(i_rst), .i_clr(clr),
      .i_slow(slow), .i_valid(txv), .i_byte(txb), .i_last(txl),
      .o_ready(txr), .o_cnt(cnt), .o_done(done));
   // count backup write strobes
   always @(posedge i_clk)
      if (bbwe === 1'h1)
         we_cnt <= we_cnt + 1;
   task test_done;
      if (error_cnt == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [135:0] seen, exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge i_clk);
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      do
      begin
         @(posedge i_clk);
         if (awv && awr)
            awv <= 1'h0;
         if (wv && wrd)
            wv <= 1'h0;
      end
      while (bv !== 1'h1);
      rsp = br;
      bry <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do
      begin
         @(posedge i_clk);
         if (arv && arr)
            arv <= 1'h0;
      end
      while (rv !== 1'h1);
      rdv = rdat;
      rsp = rr;
      rry <= 1'h0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
      input string nm);
      rd(a);
      chk(nm, rdv, e);
   endtask
   // one request, then collect whatever report follows
   task automatic pk(input logic [7:0] a, input logic [31:0] d,
      input logic [4:0] n);
      @(posedge i_clk);
      clr <= 1'h1;
      @(posedge i_clk);
      clr <= 1'h0;
      wr(a, d, 4'hf);
      repeat (300)
      begin
         @(posedge i_clk);
         if (done)
            break;
      end
      chk("report length", cnt, n);
   endtask
   // little-endian float at body byte i, counted after the id byte
   task automatic fl(input string nm, input integer i, input logic [31:0] e);
      chk(nm, {host_u.mem[i+4], host_u.mem[i+3], host_u.mem[i+2],
         host_u.mem[i+1]}, e);
   endtask
   task reset_dut;
      i_rst <= 1'h1;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'h0;
      repeat (2) @(posedge i_clk);
   endtask
   task t_defaults;
      rc(`GPRR_REG_DYN, 32'h3, "dynamics default");
      rc(`GPRR_REG_ELEV, `GPRR_ELEV_RST, "elevation default");
      rc(`GPRR_REG_OPTIONS, 32'h1, "options default");
      rd(8'h40);
      chk("unmapped resp", rsp, 2'h2);
      chk("unmapped data", rdv, 32'h0);
      wr(8'h40, 32'h0, 4'hf);
      chk("unmapped write", rsp, 2'h2);
   endtask
   task t_params;
      wr(`GPRR_REG_ELEV, 32'h3f000000, 4'hf);
      wr(`GPRR_REG_SIGL, 32'hbf800000, 4'hf);
      wr(`GPRR_REG_DYN, 32'h0, 4'hf);
      chk("backup image", bbd, {8'h3, 32'h3f000000, `GPRR_SIGL_RST,
         `GPRR_PDOP_RST, `GPRR_SWITCH_RST});
      chk("backup strobe", we_cnt != 0, 1'h1);
      slow <= 1'h1;
      pk(`GPRR_REG_CMD, 32'h2c, 5'h12);
      slow <= 1'h0;
      chk("params id", host_u.mem[0], 8'h4c);
      chk("params dynamics", host_u.mem[1], 8'h3);
      fl("elevation", 1, 32'h3f000000);
      fl("signal mask", 5, `GPRR_SIGL_RST);
      fl("pdop mask", 9, `GPRR_PDOP_RST);
      fl("pdop switch", 13, `GPRR_SWITCH_RST);
   endtask
   task t_dyn;
      integer i;
      for (i = 1; i < 6; i = i + 1)
      begin
         wr(`GPRR_REG_DYN, i, 4'hf);
         rc(`GPRR_REG_DYN, (i > 4) ? 32'h4 : i, "dynamics");
      end
   endtask
   task t_osc_time;
      wr(`GPRR_REG_OSC, 32'hc1200000, 4'hf);
      pk(`GPRR_REG_CMD, 32'h2d, 5'h5);
      chk("osc id", host_u.mem[0], 8'h4d);
      fl("osc offset", 0, 32'hc1200000);
      wr(`GPRR_REG_STATUS, 32'h0, 4'hf);
      wr(`GPRR_REG_TIME, 32'h4a000000, 4'hf);
      pk(`GPRR_REG_CMD, 32'h2e, 5'h2);
      chk("time accepted", host_u.mem[1], 8'h59);
      chk("time adopted", adopted, 1'h1);
      wr(`GPRR_REG_STATUS, 32'h1, 4'hf);
      pk(`GPRR_REG_CMD, 32'h2e, 5'h2);
      chk("time refused", host_u.mem[1], 8'h4e);
   endtask
   task t_opts;
      wr(`GPRR_REG_OPTIONS, 32'hff, 4'hf);
      rc(`GPRR_REG_OPTIONS, 32'h7f, "unused option bit");
      wr(`GPRR_REG_OPTIONS, 32'h0, 4'he);
      pk(`GPRR_REG_CMD, 32'h35, 5'h2);
      chk("options id", host_u.mem[0], 8'h55);
      chk("options byte", host_u.mem[1], 8'h7f);
   endtask
   task t_fix;
      integer i;
      wr(`GPRR_REG_BIAS, 32'h40a00000, 4'hf);
      wr(`GPRR_REG_RATE, 32'hbf800000, 4'hf);
      wr(`GPRR_REG_TFIX, 32'h44000000, 4'hf);
      pk(`GPRR_REG_STATUS, 32'h102, 5'hd);
      chk("one-sat id", host_u.mem[0], 8'h54);
      fl("bias", 0, 32'h40a00000);
      fl("bias rate", 4, 32'hbf800000);
      fl("fix time", 8, 32'h44000000);
      chk("pps correction", corr, 32'h40a00000);
      for (i = 0; i < 5; i = i + 1)
      begin
         wr(`GPRR_REG_OPTIONS, {24'h0, FIX_OPT[8*i +: 8]}, 4'hf);
         pk(`GPRR_REG_STATUS, 32'h100, FIX_LEN[8*i +: 5]);
         if (i < 4)
            chk("fix id", host_u.mem[0], FIX_ID[8*i +: 8]);
         if (i < 2)
            chk("super kind", host_u.mem[1], 8'h1 + i);
      end
   endtask
   task t_3d;
      wr(`GPRR_REG_FIX, 32'h41000000, 4'hf);
      wr(`GPRR_REG_STATUS, 32'h40, 4'hf);
      repeat (3) @(posedge i_clk);
      chk("3d four sats", fix3d, 1'h1);
      wr(`GPRR_REG_STATUS, 32'h30, 4'hf);
      repeat (3) @(posedge i_clk);
      chk("3d three sats", fix3d, 1'h0);
      wr(`GPRR_REG_STATUS, 32'h40, 4'hf);
      wr(`GPRR_REG_FIX, 32'h41500000, 4'hf);
      repeat (3) @(posedge i_clk);
      chk("3d pdop over mask", fix3d, 1'h0);
      wr(`GPRR_REG_FIX, 32'h41400000, 4'hf);
      repeat (3) @(posedge i_clk);
      chk("3d pdop at mask", fix3d, 1'h1);
   endtask
   task t_backup;
      bbv <= 1'h1;
      reset_dut;
      rc(`GPRR_REG_DYN, 32'h1, "restored dynamics");
      rc(`GPRR_REG_PDOP, 32'h3f800000, "restored pdop");
   endtask
   // main sequence
   initial
   begin
      reset_dut;
      t_defaults;
      t_params;
      t_dyn;
      t_osc_time;
      t_opts;
      t_fix;
      t_3d;
      t_backup;
      test_done;
   end
   // cut a hang short well past the expected run length
   initial
   begin
      #1000000;
      error_cnt = error_cnt + 1;
      test_done;
   end
endmodule
